// ### inc/dls_pkg.sv
// Constants and types for the double-length shift unit.
// Assumes a 24-bit word and a 32-bit AXI4-Lite register bus.
package dls_pkg;

    // ************************************************************
    // Word and instruction layout
    // ************************************************************
    localparam int WORD_W        = 24;
    localparam int CNT_W         = 5;
    localparam int OP_HI         = 23;
    localparam int OP_LO         = 18;
    localparam logic [5:0] OP_SHIFT = 6'h25;
    localparam int BIT_DOUBLE    = 11;
    localparam int BIT_LEFT      = 10;
    localparam int FILL_HI       = 9;
    localparam int FILL_LO       = 8;
    localparam logic [1:0] FILL_ZERO = 2'h0;
    localparam logic [1:0] FILL_ONE  = 2'h1;
    localparam logic [1:0] FILL_TWO  = 2'h2;
    localparam int BIT_LO_CLR    = 5;
    localparam int BIT_B23TO22   = 6;
    localparam logic [CNT_W-1:0] CNT_DONE = 5'h1F;
    localparam logic [14:0] Q_CELL = 15'h0008;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_INSTR  = 8'h04;
    localparam logic [7:0] REG_A      = 8'h08;
    localparam logic [7:0] REG_Q      = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQST  = 8'h14;
    localparam logic [7:0] REG_IRQMSK = 8'h18;
    localparam int CTRL_START = 0;
    localparam int CTRL_OVCLR = 1;
    localparam int ST_BUSY    = 0;
    localparam int ST_OVF     = 1;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_OVF    = 1;
    localparam int IRQ_BADOP  = 2;
    localparam int IRQ_W      = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_RDQ   = 5'b00010,
        ST_SHIFT = 5'b00100,
        ST_WRQ   = 5'b01000,
        ST_WREL  = 5'b10000
    } dls_state_t;

endpackage

// ### verilog/dls_shifter.sv
// One shift step of A and B for the double-length commands.
// Assumes the caller enables it only on a shift slot.
`timescale 1ns/1ps
module dls_shifter
    import dls_pkg::*;
(
    input  wire logic [WORD_W-1:0] aIn,
    input  wire logic [WORD_W-1:0] bIn,
    input  wire logic              left,
    input  wire logic [1:0]        fill,
    input  wire logic              clrB23,
    output logic      [WORD_W-1:0] aOut,
    output logic      [WORD_W-1:0] bOut,
    output logic                   signChange
);
    logic aLeftIn;
    logic aRightIn;
    logic [WORD_W-1:0] bLeft;
    logic [WORD_W-1:0] bRight;

    // Left fill of A0: zero, Q22 or Q23
    assign aLeftIn  = (fill == FILL_ONE) ? bIn[WORD_W-2] :
                      (fill == FILL_TWO) ? bIn[WORD_W-1] : 1'b0;
    // Right fill of A23: zero, A23 kept or Q0
    assign aRightIn = (fill == FILL_ONE) ? aIn[WORD_W-1] :
                      (fill == FILL_TWO) ? bIn[0] : 1'b0;
    // B left: zero into B0, B23 cleared when asked
    assign bLeft    = {bIn[WORD_W-2] & ~clrB23, bIn[WORD_W-3:0], 1'b0};
    // B right: A0 into B22 (arith, B23 clear) or B23 (circular)
    assign bRight   = clrB23 ? {1'b0, aIn[0], bIn[WORD_W-2:1]}
                             : {aIn[0], bIn[WORD_W-1:1]};
    assign aOut       = left ? {aIn[WORD_W-2:0], aLeftIn} : {aRightIn, aIn[WORD_W-1:1]};
    assign bOut       = left ? bLeft : bRight;
    assign signChange = aIn[WORD_W-1] ^ aIn[WORD_W-2];
endmodule // dls_shifter

// ### verilog/dls_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
module dls_axil_slave
    import dls_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             wrEn,
    output logic [7:0]       wrAddr,
    output logic [31:0]      wrData,
    output logic [3:0]       wrStrb,
    input  wire logic        wrErr,
    output logic             rdEn,
    output logic [7:0]       rdAddr,
    input  wire logic [31:0] rdValue,
    input  wire logic        rdErr
);
    logic       awHeld;
    logic       wHeld;
    logic       awTake;
    logic       wTake;
    logic       arTake;

    // ************************************************************
    // Write path
    // ************************************************************
    assign awready = ~awHeld & ~bvalid;
    assign wready  = ~wHeld & ~bvalid;
    assign awTake  = awvalid & awready;
    assign wTake   = wvalid & wready;
    assign wrEn    = awHeld & wHeld;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
            wrAddr <= 8'h00;
            wrData <= 32'h00000000;
            wrStrb <= 4'h0;
        end else begin
            if (awTake) begin
                awHeld <= 1'b1;
                wrAddr <= awaddr;
            end
            if (wTake) begin
                wHeld  <= 1'b1;
                wrData <= wdata;
                wrStrb <= wstrb;
            end
            if (wrEn) begin
                awHeld <= 1'b0;
                wHeld  <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= wrErr ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    assign arready = ~rvalid;
    assign arTake  = arvalid & arready;
    assign rdEn    = arTake;
    assign rdAddr  = araddr;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= RESP_OKAY;
        end else if (arTake) begin
            rvalid <= 1'b1;
            rdata  <= rdValue;
            rresp  <= rdErr ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule // dls_axil_slave

// ### verilog/dls_double_shift.sv
// Double-length shift unit: A and Q (held in memory cell 10 octal).
// Assumes a core memory port with data-ready and release handshakes.
`timescale 1ns/1ps
module dls_double_shift
    import dls_pkg::*;
#(
    parameter int ADDR_W = 15
)
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic                   memReq,
    output logic                   memWrite,
    output logic [ADDR_W-1:0]      memAddr,
    output logic [WORD_W-1:0]      memWdata,
    input  wire logic [WORD_W-1:0] memRdata,
    input  wire logic              memDataReady,
    input  wire logic              memRelease,
    output logic                   irq
);
    dls_state_t state;
    dls_state_t next_state;
    logic [WORD_W-1:0] instr;
    logic [WORD_W-1:0] regA;
    logic [WORD_W-1:0] regB;
    logic [CNT_W-1:0]  shiftCnt;
    logic              overflow_flag;
    logic              gotReady;
    logic [IRQ_W-1:0]  irqStatus;
    logic [IRQ_W-1:0]  irqMask;
    logic [IRQ_W-1:0]  irqEvent;
    logic              wrEn;
    logic [7:0]        wrAddr;
    logic [31:0]       wrData;
    logic [3:0]        wrStrb;
    logic              wrErr;
    logic              rdEn;
    logic [7:0]        rdAddr;
    logic [31:0]       rdValue;
    logic              rdErr;
    logic [WORD_W-1:0] aNext;
    logic [WORD_W-1:0] bNext;
    logic              signChange;
    logic              shift_command_class;
    logic              dblLeftLogic;
    logic              double_left_arith_cmd;
    logic              double_right_arith_cmd;
    logic              double_right_circ_cmd;
    logic              b_msb_clear_gate;
    logic              shift_time_slot;
    logic              cntDone;
    logic              startCmd;
    logic              startGo;
    logic              badOp;
    logic              wrCtrl;
    logic              idle;

    // ************************************************************
    // Command decode
    // ************************************************************
    assign shift_command_class    = (instr[OP_HI:OP_LO] == OP_SHIFT) && instr[BIT_DOUBLE];
    assign double_left_arith_cmd  = shift_command_class && instr[BIT_LEFT]
                                    && (instr[FILL_HI:FILL_LO] == FILL_ONE);
    assign double_right_arith_cmd = shift_command_class && !instr[BIT_LEFT]
                                    && (instr[FILL_HI:FILL_LO] == FILL_ONE);
    assign double_right_circ_cmd  = shift_command_class && !instr[BIT_LEFT]
                                    && (instr[FILL_HI:FILL_LO] == FILL_TWO);
    assign dblLeftLogic           = shift_command_class && instr[BIT_LEFT]
                                    && (instr[FILL_HI:FILL_LO] == FILL_TWO);
    assign b_msb_clear_gate       = double_left_arith_cmd | double_right_arith_cmd;
    assign badOp                  = !shift_command_class || (&instr[FILL_HI:FILL_LO]);
    assign idle                   = (state == ST_IDLE);
    assign wrCtrl                 = wrEn && (wrAddr == REG_CTRL) && wrStrb[0];
    assign startCmd               = wrCtrl && wrData[CTRL_START] && idle;
    assign startGo                = startCmd && !badOp;

    // ************************************************************
    // Sequencer
    // ************************************************************
    assign cntDone         = (shiftCnt == CNT_DONE);
    assign shift_time_slot = (state == ST_SHIFT) && !cntDone;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:  if (startGo) next_state = ST_RDQ;
            ST_RDQ:   if ((gotReady || memDataReady) && memRelease) next_state = ST_SHIFT;
            ST_SHIFT: if (cntDone) next_state = ST_WRQ;
            ST_WRQ:   next_state = ST_WREL;
            ST_WREL:  if (memRelease) next_state = ST_IDLE;
        endcase
    end

    assign memReq   = (state == ST_RDQ) || (state == ST_WRQ);
    assign memWrite = (state == ST_WRQ);
    assign memAddr  = ADDR_W'(Q_CELL);
    assign memWdata = regB;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state    <= ST_IDLE;
            gotReady <= 1'b0;
        end else begin
            state    <= next_state;
            gotReady <= (state == ST_RDQ) && (gotReady || memDataReady) && !memRelease;
        end
    end

    // ************************************************************
    // Datapath
    // ************************************************************
    dls_shifter u_shifter (
        .aIn        (regA),
        .bIn        (regB),
        .left       (instr[BIT_LEFT]),
        .fill       (instr[FILL_HI:FILL_LO]),
        .clrB23     (b_msb_clear_gate),
        .aOut       (aNext),
        .bOut       (bNext),
        .signChange (signChange)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regA     <= '0;
            regB     <= '0;
            instr    <= '0;
            shiftCnt <= '0;
        end else begin
            if (wrEn && idle && (wrAddr == REG_INSTR)) instr <= wrData[WORD_W-1:0];
            if (wrEn && idle && (wrAddr == REG_A)) regA <= wrData[WORD_W-1:0];
            if (startGo) shiftCnt <= ~instr[CNT_W-1:0];
            if ((state == ST_RDQ) && memDataReady) regB <= memRdata;
            if (shift_time_slot) begin
                regA     <= aNext;
                regB     <= bNext;
                shiftCnt <= shiftCnt + 5'h01;
            end
        end
    end

    // Overflow is sticky; only software clears it, set wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            overflow_flag <= 1'b0;
        end else if (shift_time_slot && double_left_arith_cmd && signChange) begin
            overflow_flag <= 1'b1;
        end else if (wrCtrl && wrData[CTRL_OVCLR]) begin
            overflow_flag <= 1'b0;
        end
    end

    // ************************************************************
    // Interrupts and registers
    // ************************************************************
    assign irqEvent[IRQ_DONE]  = (state == ST_WREL) && memRelease;
    assign irqEvent[IRQ_OVF]   = shift_time_slot && double_left_arith_cmd && signChange;
    assign irqEvent[IRQ_BADOP] = startCmd && badOp;
    assign irq                 = |(irqStatus & irqMask);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqStatus <= '0;
            irqMask   <= '0;
        end else begin
            if (wrEn && (wrAddr == REG_IRQMSK)) irqMask <= wrData[IRQ_W-1:0];
            if (wrEn && (wrAddr == REG_IRQST)) irqStatus <= (irqStatus & ~wrData[IRQ_W-1:0]) | irqEvent;
            else irqStatus <= irqStatus | irqEvent;
        end
    end

    assign wrErr = !((wrAddr == REG_CTRL) || (wrAddr == REG_INSTR) || (wrAddr == REG_A)
                     || (wrAddr == REG_IRQST) || (wrAddr == REG_IRQMSK));
    assign rdErr = !((rdAddr == REG_CTRL) || (rdAddr == REG_INSTR) || (rdAddr == REG_A)
                     || (rdAddr == REG_Q) || (rdAddr == REG_STATUS)
                     || (rdAddr == REG_IRQST) || (rdAddr == REG_IRQMSK));
    assign rdValue = (rdAddr == REG_INSTR)  ? {8'h00, instr} :
                     (rdAddr == REG_A)      ? {8'h00, regA} :
                     (rdAddr == REG_Q)      ? {8'h00, regB} :
                     (rdAddr == REG_STATUS) ? {30'h00000000, overflow_flag, !idle} :
                     (rdAddr == REG_IRQST)  ? {29'h00000000, irqStatus} :
                     (rdAddr == REG_IRQMSK) ? {29'h00000000, irqMask} : 32'h00000000;

    dls_axil_slave u_bus (
        .ref_clk (ref_clk),
        .rst     (rst),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wrEn    (wrEn),
        .wrAddr  (wrAddr),
        .wrData  (wrData),
        .wrStrb  (wrStrb),
        .wrErr   (wrErr),
        .rdEn    (rdEn),
        .rdAddr  (rdAddr),
        .rdValue (rdValue),
        .rdErr   (rdErr)
    );

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence startSeq;
        startGo;
    endsequence
    sequence presetSeq;
        ##1 (shiftCnt == ~$past(instr[CNT_W-1:0]));
    endsequence
    sequence memWaitSeq;
        (state == ST_RDQ) && !memRelease;
    endsequence

    cnt_preset_a: assert property (@(posedge ref_clk) disable iff (rst)
        startSeq |-> presetSeq) else $error("counter not preset");
    cnt_step_a: assert property (@(posedge ref_clk) disable iff (rst)
        shift_time_slot |=> (shiftCnt == $past(shiftCnt) + 5'h01)) else $error("counter step");
    shift_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == ST_SHIFT) && cntDone |=> (state == ST_WRQ) && $stable(regA)) else $error("no stop");
    write_back_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == ST_WRQ) |-> memWrite && (memWdata == regB) && (memAddr == ADDR_W'(Q_CELL)))
        else $error("bad write back");
    read_q_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == ST_RDQ) && memDataReady |=> (regB == $past(memRdata))) else $error("Q not loaded");
    dla_fill_a: assert property (@(posedge ref_clk) disable iff (rst)
        shift_time_slot && double_left_arith_cmd |=>
        (regA[0] == $past(regB[WORD_W-2])) && !regB[WORD_W-1] && !regB[0]) else $error("left fill");
    ovf_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        shift_time_slot && double_left_arith_cmd && signChange |=> overflow_flag) else $error("ovf");
    ovf_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        shift_time_slot && !double_left_arith_cmd && !wrCtrl |=> $stable(overflow_flag))
        else $error("ovf changed");
    dra_sign_a: assert property (@(posedge ref_clk) disable iff (rst)
        shift_time_slot && double_right_arith_cmd |=>
        $stable(regA[WORD_W-1]) && !regB[WORD_W-1] && (regB[WORD_W-2] == $past(regA[0])))
        else $error("right arith");
    drc_rot_a: assert property (@(posedge ref_clk) disable iff (rst)
        shift_time_slot && double_right_circ_cmd |=>
        (regA[WORD_W-1] == $past(regB[0])) && (regB[WORD_W-1] == $past(regA[0]))) else $error("rotate");
    rdq_enter_a: assert property (@(posedge ref_clk) disable iff (rst)
        startSeq |=> memReq && !memWrite) else $error("no Q read");
    rdq_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        memWaitSeq |=> (state == ST_RDQ)) else $error("shift before release");
    slot_only_a: assert property (@(posedge ref_clk) disable iff (rst)
        !idle && !shift_time_slot |=> $stable(regA)) else $error("A moved off slot");
    dll_fill_a: assert property (@(posedge ref_clk) disable iff (rst)
        shift_time_slot && dblLeftLogic |=>
        (regA[0] == $past(regB[WORD_W-1])) && (regB[WORD_W-1] == $past(regB[WORD_W-2])) && !regB[0])
        else $error("left logical fill");
    write_once_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == ST_WRQ) |=> !memWrite) else $error("write held");
    bad_op_a: assert property (@(posedge ref_clk) disable iff (rst)
        startCmd && badOp |=> idle) else $error("bad opcode ran");
    ovf_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        overflow_flag && !(wrCtrl && wrData[CTRL_OVCLR]) |=> overflow_flag) else $error("ovf lost");
endmodule // dls_double_shift

// ### sim/dls_mem_model.sv
// Core memory model holding the Q word of the shift unit.
// Assumes one clock; lat sets the answer delay in cycles.
`timescale 1ns/1ps
module dls_mem_model
    import dls_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              memReq,
    input  wire logic              memWrite,
    input  wire logic [WORD_W-1:0] memWdata,
    output logic      [WORD_W-1:0] memRdata,
    output logic                   memDataReady,
    output logic                   memRelease
);
    logic [WORD_W-1:0] q = '0;
    int                lat = 0;
    int                cnt = 0;
    logic              armed;
    logic              pend;

    // Data lines toggle every cycle unless a read answer is shown
    always @(posedge ref_clk) begin
        memRelease <= 1'b0;
        memRdata <= (pend && cnt >= lat && !memWrite) ? q : ~memRdata;
        if (rst) begin
            memRdata <= '0;
            pend <= 1'b0;
            armed <= 1'b1;
            memDataReady <= 1'b0;
        end else begin
            if (!memReq && !pend) armed <= 1'b1;
            if (memWrite) begin
                q <= memWdata;
                pend <= 1'b1;
                cnt <= 0;
                armed <= 1'b0;
            end else if (memReq && armed) begin
                pend <= 1'b1;
                cnt <= 0;
                armed <= 1'b0;
            end else if (pend) begin
                cnt <= cnt + 1;
                if (cnt >= lat) memDataReady <= 1'b1;
                if (cnt == lat + 1) begin
                    memRelease <= 1'b1;
                    pend <= 1'b0;
                end
            end
            if (memRelease) memDataReady <= 1'b0;
        end
    end
endmodule // dls_mem_model

// ### sim/double_length_shift_unit_tb.sv
// Self-checking bench for the double-length shift unit.
// Assumes dls_pkg, the design and dls_mem_model are compiled first.
`timescale 1ns/1ps
module double_length_shift_unit_tb;
    import dls_pkg::*;
    logic        ref_clk = 1'b0, rst = 1'b1;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, memReq, memWrite;
    logic        memDataReady, memRelease;
    logic [1:0]  bresp, rresp, resp;
    logic [14:0] memAddr;
    logic [23:0] memWdata, memRdata;
    int          errors = 0, n_compared = 0, seed = 32'hCA52;
    logic [14:0] cmdLow [4] = '{15'h0D20, 15'h0E80, 15'h0900, 15'h0AC0};

    dls_double_shift dls_double_shift_i (.ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .memReq, .memWrite, .memAddr, .memWdata, .memRdata, .memDataReady,
        .memRelease, .irq);
    dls_mem_model mem_i (.ref_clk, .rst, .memReq, .memWrite, .memWdata, .memRdata, .memDataReady,
        .memRelease);

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Checks and bus tasks
    // ************************************************************
    task automatic end_of_test();
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic guard(input int n, input int lim);
        if (n >= lim) begin
            errors++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 200);
        resp = bresp;
        bready <= 1'b0;
        guard(n, 200);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 200);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        guard(n, 200);
    endtask

    // One shift per step on A and Q, overflow sticky
    function automatic void model(input int op, input int k, inout logic [23:0] a, inout logic [23:0] b,
                                  inout logic ov);
        for (int i = 0; i < k; i++) begin
            case (op)
                0: {ov, a, b} = {ov | (a[23] ^ a[22]), a[22:0], b[22], 1'b0, b[21:0], 1'b0};
                1: {a, b} = {a[22:0], b[23], b[22:0], 1'b0};
                2: {a, b} = {a[23], a[23:1], 1'b0, a[0], b[22:1]};
                default: {a, b} = {b[0], a[23:1], a[0], b[23:1]};
            endcase
        end
    endfunction

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int k, op, n;
        logic [23:0] a, b;
        logic ov;
        logic [31:0] d;
        ov = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        rd(REG_STATUS, d);
        chk(d, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd(8'h1C, d);
        chk(32'(resp), 32'(RESP_SLVERR));
        wr(8'h1C, 32'h1);
        chk(32'(resp), 32'(RESP_SLVERR));
        wr(REG_IRQMSK, 32'h5);
        for (int i = 0; i < 12; i++) begin
            op = i % 4;
            k = (i < 4) ? 31 : 1 + ($unsigned($random(seed)) % 31);
            a = (i == 4) ? 24'h0 : 24'($random(seed));
            b = 24'($random(seed));
            mem_i.q = b;
            mem_i.lat = $unsigned($random(seed)) % 4;
            if (op == 0) begin
                wr(REG_CTRL, 32'h2);
                ov = 1'b0;
            end
            wr(REG_A, {8'h00, a});
            wr(REG_INSTR, {8'h00, OP_SHIFT, 3'h0, cmdLow[op] | 15'(k)});
            wr(REG_CTRL, 32'h1);
            model(op, k, a, b, ov);
            n = 0;
            do begin
                rd(REG_STATUS, d);
                n++;
            end while (d[ST_BUSY] !== 1'b0 && n < 100);
            guard(n, 100);
            chk(d, {30'h0, ov, 1'b0});
            rd(REG_A, d);
            chk(d, {8'h00, a});
            chk({8'h00, mem_i.q}, {8'h00, b});
            rd(REG_Q, d);
            chk(d, {8'h00, b});
            chk({17'h0, memAddr}, 32'h8);
            chk({31'h0, irq}, 32'h1);
            wr(REG_IRQST, 32'h7);
            chk({31'h0, irq}, 32'h0);
        end
        wr(REG_IRQMSK, 32'h0);
        wr(REG_INSTR, {8'h00, OP_SHIFT, 3'h0, 15'h0F03});
        wr(REG_CTRL, 32'h1);
        rd(REG_IRQST, d);
        chk(d, 32'h4);
        chk({31'h0, irq}, 32'h0);
        rd(REG_A, d);
        chk(d, {8'h00, a});
        wr(REG_IRQMSK, 32'h4);
        chk({31'h0, irq}, 32'h1);
        wr(REG_IRQST, 32'h4);
        chk({31'h0, irq}, 32'h0);
        end_of_test();
    end
endmodule // double_length_shift_unit_tb
